/* design/tvsd_i2c_if.sv */
// two-wire link between the controller and the sound decoder
// resolves open-drain levels; a released line reads high
`timescale 1ns/1ps
interface tvsd_i2c_if;
    logic scl_o_m;
    logic scl_oe_m;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;
    logic scl;
    logic sda;
    assign scl = !(scl_oe_m && !scl_o_m);
    assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
    modport ctrl (input scl, sda, output scl_o_m, scl_oe_m, sda_o_m, sda_oe_m);
    modport dev (input scl, sda, output sda_o_s, sda_oe_s);
endinterface // tvsd_i2c_if

/* design/tvsd_i2c_master.sv */
// serial bus controller for the sound decoder, run by software over wishbone
// assumes the decoder never stretches the clock for long; scl_i low only stalls
`timescale 1ns/1ps
module tvsd_i2c_master
    import tvsd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial link
    tvsd_i2c_if.ctrl link
);
    typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} mst_state_t;

    mst_state_t state;
    logic [1:0] ph;
    logic [8:0] tick;
    logic [3:0] bitn;
    logic [8:0] txv;
    logic [8:0] rxv;
    logic [2:0] idx;
    op_t op;
    logic [1:0] cnt;
    logic asel;
    logic [31:0] txw;
    logic nack_err;
    logic [7:0] rx_data;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] in_a;
    logic [1:0] in_b;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_a <= 2'h3;
            in_b <= 2'h3;
        end else if (ce_i) begin
            in_a <= {link.scl, link.sda};
            in_b <= in_a;
        end
    end

    wire logic scl_s = in_b[1];
    wire logic sda_s = in_b[0];
    wire logic busy = state != M_IDLE;
    wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic cmd_go = wb_req && wb_we_i && wb_adr_i == REG_CMD && wb_sel_i[0] && !busy;
    wire logic stall = !scl_oe && !scl_s;
    wire logic tick_done = tick == 9'h000 && !stall;
    wire logic [2:0] last_idx = op == OP_IDENT ? 3'h3 : {1'b0, cnt} + 3'h1;
    wire logic [2:0] nxt_idx = idx + 3'h1;
    wire logic is_last = idx == last_idx;
    wire logic cur_rd = (op == OP_STATUS && idx != 3'h0) || (op == OP_IDENT && idx == 3'h3);

    // read bytes release sda and answer ack, or nack on the last
    function automatic logic [8:0] frame(input logic [2:0] i);
        logic [7:0] b;
        b = 8'hff;
        unique case (op)
            OP_WRITE: b = i == 3'h0 ? {SLAVE_ADDR_HI, asel, 1'b0} :
                          i == 3'h1 ? txw[7:0] : txw[8 * (i - 3'h1) +: 8];
            OP_STATUS: b = i == 3'h0 ? {SLAVE_ADDR_HI, asel, 1'b1} : 8'hff;
            OP_IDENT: b = i == 3'h0 ? {SLAVE_ADDR_HI, asel, 1'b0} :
                          i == 3'h1 ? SUB_IDENTITY :
                          i == 3'h2 ? {SLAVE_ADDR_HI, asel, 1'b1} : 8'hff;
            default: b = 8'hff;
        endcase
        if ((op == OP_STATUS && i != 3'h0) || (op == OP_IDENT && i == 3'h3)) begin
            frame = {8'hff, i == last_idx};
        end else begin
            frame = {b, 1'b1};
        end
    endfunction

    // quarter-period ticks keep scl at or below its ceiling
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick <= 9'h000;
        end else if (ce_i) begin
            if (!busy || tick_done) begin
                tick <= SCL_QTR_CYC - 9'h001;
            end else if (!stall && tick != 9'h000) begin
                tick <= tick - 9'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= M_IDLE;
            ph <= 2'h0;
            bitn <= 4'h0;
            txv <= 9'h1ff;
            rxv <= 9'h000;
            idx <= 3'h0;
            op <= OP_WRITE;
            cnt <= 2'h0;
            asel <= 1'b1;
            nack_err <= 1'b0;
            rx_data <= 8'h00;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce_i) begin
            if (cmd_go) begin
                // ident response changes are sequenced by software
                op <= op_t'(wb_dat_i[CMD_OP_LSB +: 2]);
                cnt <= wb_dat_i[CMD_CNT_LSB +: 2];
                asel <= wb_dat_i[CMD_ASEL_BIT];
                idx <= 3'h0;
                nack_err <= 1'b0;
                ph <= 2'h0;
                state <= M_START;
            end else if (busy && tick_done) begin
                ph <= ph + 2'h1;
                unique case (state)
                    M_START: begin
                        unique case (ph)
                            2'h0: sda_oe <= 1'b0;
                            2'h1: scl_oe <= 1'b0;
                            2'h2: sda_oe <= 1'b1;
                            2'h3: begin
                                scl_oe <= 1'b1;
                                txv <= frame(idx);
                                bitn <= 4'h0;
                                state <= M_BYTE;
                            end
                        endcase
                    end
                    M_BYTE: begin
                        unique case (ph)
                            2'h0: sda_oe <= !txv[8];
                            2'h1: scl_oe <= 1'b0;
                            2'h2: rxv <= {rxv[7:0], sda_s};
                            2'h3: begin
                                scl_oe <= 1'b1;
                                txv <= {txv[7:0], 1'b1};
                                bitn <= bitn + 4'h1;
                                if (bitn == 4'h8) begin
                                    idx <= nxt_idx;
                                    bitn <= 4'h0;
                                    if (cur_rd) begin
                                        rx_data <= rxv[8:1];
                                    end
                                    if (!cur_rd && rxv[0]) begin
                                        nack_err <= 1'b1;
                                        state <= M_STOP;
                                    end else if (is_last) begin
                                        state <= M_STOP;
                                    end else if (op == OP_IDENT && idx == 3'h1) begin
                                        state <= M_START;
                                    end else begin
                                        txv <= frame(nxt_idx);
                                    end
                                end
                            end
                        endcase
                    end
                    M_STOP: begin
                        unique case (ph)
                            2'h0: sda_oe <= 1'b1;
                            2'h1: scl_oe <= 1'b0;
                            2'h2: sda_oe <= 1'b0;
                            2'h3: state <= M_IDLE;
                        endcase
                    end
                    default: state <= M_IDLE;
                endcase
            end
        end
    end

    wire logic [31:0] stat_word = {16'h0000, rx_data, 6'h00, nack_err, busy};
    wire logic [31:0] rd_mux = wb_adr_i == REG_TXW ? txw :
                               wb_adr_i == REG_STAT ? stat_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            txw <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_mux;
            end
            if (wb_req && wb_we_i && wb_adr_i == REG_TXW) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_i[i]) begin
                        txw[8 * i +: 8] <= wb_dat_i[8 * i +: 8];
                    end
                end
            end
        end
    end

    assign link.scl_o_m = 1'b0;
    assign link.scl_oe_m = scl_oe;
    assign link.sda_o_m = 1'b0;
    assign link.sda_oe_m = sda_oe;
endmodule // tvsd_i2c_master

/* design/tvsd_i2c_slave.sv */
// serial control slave of the stereo sound decoder: control registers and status
// assumes link, strap and ident inputs are asynchronous to clk_i
//
`timescale 1ns/1ps
module tvsd_i2c_slave
    import tvsd_pkg::*;
#(
    parameter logic [7:0] IDENT_CODE = 8'h5a // arbitrary value
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // serial link
    tvsd_i2c_if.dev link,
    // strap and decoder state, asynchronous
    input wire logic address_select_pin_i,
    input wire logic stereo_ident_flag_i,
    input wire logic dual_ident_flag_i,
    input wire logic supply_breakdown_i,
    // control fields
    output logic [1:0] source_select_o,
    output logic [1:0] output_select_o,
    output logic decoder_stereo_setting_o,
    output logic output_level_o,
    output logic output_mute_o,
    output logic auto_mute_enable_o,
    output logic [3:0] channel_gain_trim_o,
    output logic [2:0] tv_standard_select_o,
    output logic ident_response_time_o,
    output logic port1_out_o,
    output logic port2_out_o,
    output logic test_mode_bit_o,
    output logic [2:0] mono_out_select_o,
    output logic powerup_flag_o
);
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_SUB, S_SUB_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
    } slv_state_t;

    logic [5:0] in_a;
    logic [5:0] in_b;
    logic scl_p;
    logic sda_p;
    slv_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic id_sel;
    logic sda_oe;
    logic powerup_flag;
    logic [7:0] audio_switching;
    logic [7:0] adjust_and_standard;
    logic [7:0] port_and_mono_out;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_a <= 6'h03;
            in_b <= 6'h03;
        end else if (ce_i) begin
            in_a <= {address_select_pin_i, stereo_ident_flag_i, dual_ident_flag_i,
                     supply_breakdown_i, link.scl, link.sda};
            in_b <= in_a;
        end
    end

    wire logic pin_s = in_b[5];
    wire logic st_s = in_b[4];
    wire logic ds_s = in_b[3];
    wire logic bd_s = in_b[2];
    wire logic scl_s = in_b[1];
    wire logic sda_s = in_b[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else if (ce_i) begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    wire logic scl_rise = scl_s && !scl_p;
    wire logic scl_fall = !scl_s && scl_p;
    wire logic start_cond = scl_s && scl_p && sda_p && !sda_s;
    wire logic stop_cond = scl_s && scl_p && !sda_p && sda_s;
    wire logic got_byte = cnt == 4'h8;
    wire logic [6:0] own_addr = {SLAVE_ADDR_HI, pin_s};
    wire logic addr_hit = shreg[7:1] == own_addr;
    // undefined bits read as zero
    wire logic [7:0] status_byte = {STATUS_TOP, 2'h0, ds_s, st_s, powerup_flag};
    wire logic [7:0] tx_byte = id_sel ? IDENT_CODE : status_byte;
    wire logic wr_strobe = scl_fall && state == S_WR && got_byte;
    // a byte counts as read once the master answers it, ack or not
    wire logic stat_done = scl_rise && state == S_RD_ACK && !id_sel;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            id_sel <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce_i) begin
            if (stop_cond) begin
                state <= S_IDLE;
                sda_oe <= 1'b0;
                id_sel <= 1'b0;
            end else if (start_cond) begin
                // repeated start keeps id_sel for the identity read
                state <= S_ADDR;
                cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    S_IDLE: begin
                        cnt <= 4'h0;
                    end
                    S_ADDR, S_SUB, S_WR: begin
                        if (scl_rise && !got_byte) begin
                            shreg <= {shreg[6:0], sda_s};
                            cnt <= cnt + 4'h1;
                        end
                        if (scl_fall && got_byte) begin
                            cnt <= 4'h0;
                            if (state == S_ADDR && !addr_hit) begin
                                state <= S_IDLE;
                            end else begin
                                sda_oe <= 1'b1;
                            end
                            if (state == S_ADDR && addr_hit) begin
                                rw <= shreg[0];
                                state <= S_ADDR_ACK;
                            end
                            if (state == S_SUB) begin
                                ptr <= shreg;
                                id_sel <= shreg == SUB_IDENTITY;
                                state <= S_SUB_ACK;
                            end
                            if (state == S_WR) begin
                                ptr <= ptr + 8'h01;
                                state <= S_WR_ACK;
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        if (scl_fall && rw) begin
                            sda_oe <= !tx_byte[7];
                            shreg <= {tx_byte[6:0], 1'b0};
                            cnt <= 4'h1;
                            state <= S_RD;
                        end else if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= S_SUB;
                        end
                    end
                    S_SUB_ACK, S_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= S_WR;
                        end
                    end
                    S_RD: begin
                        if (scl_fall && got_byte) begin
                            sda_oe <= 1'b0;
                            state <= S_RD_ACK;
                        end else if (scl_fall) begin
                            sda_oe <= !shreg[7];
                            shreg <= {shreg[6:0], 1'b0};
                            cnt <= cnt + 4'h1;
                        end
                    end
                    S_RD_ACK: begin
                        if (scl_rise && sda_s) begin
                            state <= S_IDLE;
                        end else if (scl_fall) begin
                            // master acked: send the byte again
                            sda_oe <= !tx_byte[7];
                            shreg <= {tx_byte[6:0], 1'b0};
                            cnt <= 4'h1;
                            state <= S_RD;
                        end
                    end
                endcase
            end
        end
    end

    // writes past the port register are acked and dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            audio_switching <= RST_SWITCHING;
            adjust_and_standard <= RST_ADJUST;
            port_and_mono_out <= RST_PORT;
        end else if (ce_i && wr_strobe) begin
            if (ptr == SUB_SWITCHING) begin
                audio_switching <= shreg;
            end else if (ptr == SUB_ADJUST) begin
                adjust_and_standard <= shreg;
            end else if (ptr == SUB_PORT) begin
                port_and_mono_out <= shreg & PORT_WMASK;
            end
        end
    end

    // a breakdown in the same cycle as the read wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powerup_flag <= 1'b1;
        end else if (ce_i) begin
            if (bd_s) begin
                powerup_flag <= 1'b1;
            end else if (stat_done) begin
                powerup_flag <= 1'b0;
            end
        end
    end

    assign link.sda_o_s = 1'b0;
    assign link.sda_oe_s = sda_oe;
    assign powerup_flag_o = powerup_flag;
    // field slices drive the analog switching directly
    assign source_select_o = audio_switching[SRC_LSB +: 2];
    assign output_select_o = audio_switching[OSEL_LSB +: 2];
    assign decoder_stereo_setting_o = audio_switching[DSTEREO_BIT];
    assign output_level_o = audio_switching[OLEVEL_BIT];
    assign output_mute_o = audio_switching[MUTE_BIT];
    assign auto_mute_enable_o = audio_switching[AUTOMUTE_BIT];
    assign channel_gain_trim_o = adjust_and_standard[TRIM_LSB +: 4];
    assign tv_standard_select_o = adjust_and_standard[STD_LSB +: 3];
    assign ident_response_time_o = adjust_and_standard[FAST_BIT];
    assign port1_out_o = port_and_mono_out[P1_BIT];
    assign port2_out_o = port_and_mono_out[P2_BIT];
    assign test_mode_bit_o = port_and_mono_out[TEST_BIT];
    assign mono_out_select_o = port_and_mono_out[MONO_LSB +: 3];
endmodule // tvsd_i2c_slave

/* design/tvsd_pkg.sv */
// constants shared by both ends of the sound decoder control link
// assumes a 125 MHz system clock on both ends
package tvsd_pkg;
    // seven-bit slave address is these six bits plus the strap bit
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h2d;
    localparam logic [7:0] SUB_SWITCHING = 8'h00;
    localparam logic [7:0] SUB_ADJUST = 8'h01;
    localparam logic [7:0] SUB_PORT = 8'h02;
    localparam logic [7:0] SUB_IDENTITY = 8'hfe;
    localparam logic [7:0] RST_SWITCHING = 8'hc0;
    localparam logic [7:0] RST_ADJUST = 8'h06;
    localparam logic [7:0] RST_PORT = 8'h3b;
    localparam logic [7:0] PORT_WMASK = 8'h3f;
    localparam logic [2:0] STATUS_TOP = 3'h4;
    // field positions
    localparam int SRC_LSB = 0;
    localparam int OSEL_LSB = 2;
    localparam int DSTEREO_BIT = 4;
    localparam int OLEVEL_BIT = 5;
    localparam int MUTE_BIT = 6;
    localparam int AUTOMUTE_BIT = 7;
    localparam int TRIM_LSB = 0;
    localparam int STD_LSB = 4;
    localparam int FAST_BIT = 7;
    localparam int P1_BIT = 0;
    localparam int P2_BIT = 1;
    localparam int TEST_BIT = 2;
    localparam int MONO_LSB = 3;
    // serial clock timing
    localparam int CLK_KHZ = 125000;
    localparam int SCL_MAX_KHZ = 100;
    localparam logic [8:0] SCL_QTR_CYC = 9'((CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ));
    // controller registers on its wishbone port
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_TXW = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_CNT_LSB = 2;
    localparam int CMD_ASEL_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_RX_LSB = 8;
    typedef enum logic [1:0] {OP_WRITE, OP_STATUS, OP_IDENT} op_t;
endpackage

/* dv/tb_top.sv */
// bench: controller driven over wishbone talks to the decoder across the link
// assumes one shared 125 MHz clock; link timing from the package quarter period
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    import tvsd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pin = 1'b1;
    logic st = 1'b1;
    logic ds = 1'b0;
    logic brk = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] wb_dat_o;
    logic we = 1'b0;
    logic stb = 1'b0;
    logic wb_ack_o;
    logic [1:0] src, osel;
    logic dst, olev, mute, amute, fast, p1, p2, tst, pwr;
    logic [3:0] trim;
    logic [2:0] std, mono;
    int bad_count = 0;
    int check_count = 0;
    int cyc_n = 0;
    tvsd_i2c_if link();
    tvsd_i2c_master tvsd_i2c_master_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link.ctrl));
    // identity value is arbitrary
    tvsd_i2c_slave #(.IDENT_CODE(8'h3c)) tvsd_i2c_slave_i (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .link(link.dev), .address_select_pin_i(pin), .stereo_ident_flag_i(st),
        .dual_ident_flag_i(ds), .supply_breakdown_i(brk), .source_select_o(src),
        .output_select_o(osel), .decoder_stereo_setting_o(dst), .output_level_o(olev),
        .output_mute_o(mute), .auto_mute_enable_o(amute), .channel_gain_trim_o(trim),
        .tv_standard_select_o(std), .ident_response_time_o(fast), .port1_out_o(p1),
        .port2_out_o(p2), .test_mode_bit_o(tst), .mono_out_select_o(mono), .powerup_flag_o(pwr));
    tvsd_checker tvsd_checker_i (.clk_i(clk_i), .rst_i(rst_i), .scl(link.scl), .sda(link.sda),
        .scl_o_m(link.scl_o_m), .scl_oe_m(link.scl_oe_m), .sda_oe_m(link.sda_oe_m),
        .sda_o_s(link.sda_o_s), .sda_oe_s(link.sda_oe_s));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 32'h0003_0d40) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr <= a;
        we <= w;
        dat <= d;
        stb <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    // load, start, then poll status until the link goes idle
    task automatic run(input logic [31:0] txw, input logic [31:0] cmd, input logic exp_nack);
        wb(REG_TXW, 1'b1, txw);
        wb(REG_CMD, 1'b1, cmd);
        do wb(REG_STAT, 1'b0, 32'h0000_0000); while (rd[STAT_BUSY_BIT] !== 1'b0);
        `CHK(rd[STAT_NACK_BIT], exp_nack)
    endtask
    task automatic t_reset();
        `CHK({amute, mute, olev, dst, osel, src}, RST_SWITCHING)
        `CHK({fast, std, trim}, RST_ADJUST)
        `CHK({2'b00, mono, tst, p2, p1}, RST_PORT)
        `CHK(pwr, 1'b1)
    endtask
    // three data bytes from subaddress 0 land in all three registers
    task automatic t_write();
        run(32'hffd5_3a00, 32'h0000_001c, 1'b0);
        `CHK({amute, mute, olev, dst, osel, src}, 8'h3a)
        `CHK({fast, std, trim}, 8'hd5)
        `CHK({2'b00, mono, tst, p2, p1}, PORT_WMASK)
    endtask
    // two status bytes: the repeat shows the flag cleared by the first
    task automatic t_status();
        run(32'h0000_0000, 32'h0000_0015, 1'b0);
        `CHK(rd[15:8], {STATUS_TOP, 2'b00, ds, st, 1'b0})
        `CHK(pwr, 1'b0)
        // a supply breakdown raises the flag again past the two-stage sync
        brk <= 1'b1;
        repeat (4) @(posedge clk_i);
        brk <= 1'b0;
        `CHK(pwr, 1'b1)
    endtask
    // grounded strap, matching address bit clear
    task automatic t_ident();
        pin <= 1'b0;
        run(32'h0000_00fe, 32'h0000_0002, 1'b0);
        `CHK(rd[15:8], 8'h3c)
    endtask
    // strap still grounded: the open-strap address must go unanswered
    task automatic t_foreign();
        run(32'h0000_5500, 32'h0000_0014, 1'b1);
        `CHK({amute, mute, olev, dst, osel, src}, 8'h3a)
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_write();
        t_status();
        t_ident();
        t_foreign();
        report_and_stop();
    end
endmodule // tb_top

/* dv/tvsd_checker.sv */
// link checker: watches both open-drain ends of the decoder link
// assumes scl and sda are the resolved levels of the interface
`timescale 1ns/1ps
module tvsd_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o_m,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_o_s,
    input wire logic sda_oe_s
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [19:0] hi_cnt;
    logic [19:0] lo_cnt;
    logic [19:0] oe_cnt;
    // wide enough that the whole run never wraps them
    wire [19:0] next_hi = scl ? hi_cnt + 20'h0_0001 : 20'h0_0000;
    wire [19:0] next_lo = scl ? 20'h0_0000 : lo_cnt + 20'h0_0001;
    wire [19:0] next_oe = sda_oe_s ? oe_cnt + 20'h0_0001 : 20'h0_0000;
    always_ff @(posedge clk_i) begin
        hi_cnt <= rst_i ? 20'h0_0000 : next_hi;
        lo_cnt <= rst_i ? 20'h0_0000 : next_lo;
        oe_cnt <= rst_i ? 20'h0_0000 : next_oe;
    end
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !sda_oe_s && !scl_oe_m)
        else $error("link driven just after reset");
    a_open_drain: assert property (!sda_o_s && (!scl_oe_m || !scl_o_m))
        else $error("line driven high");
    a_slave_after_fall: assert property ($changed(sda_oe_s) |-> !scl && lo_cnt inside {[1:12]})
        else $error("decoder moved sda outside the low clock phase");
    a_scl_high_min: assert property ($fell(scl) |-> hi_cnt >= 20'h0_0258)
        else $error("scl high phase too short");
    a_scl_low_min: assert property ($rose(scl) |-> lo_cnt >= 20'h0_0258)
        else $error("scl low phase too short");
    a_slave_hold_bound: assert property (sda_oe_s |-> oe_cnt < 20'h0_2c24)
        else $error("decoder holds sda longer than a byte");
    a_start_by_ctrl: assert property ($changed(sda) && scl |-> $changed(sda_oe_m))
        else $error("sda moved under high scl by the decoder");
    a_sda_stable_high: assert property (scl && $past(scl) && $stable(sda_oe_m) |-> $stable(sda))
        else $error("sda changed during high scl");
endmodule // tvsd_checker
